/* pmsm_params.svh */
/*
 * Constants of the transceiver management serial master: register
 * offsets, field positions, reset values and serial timing counts.
 * Assumes it is included by its bare name; holds definitions only.
 */
`ifndef PMSM_PARAMS_SVH
`define PMSM_PARAMS_SVH

// ********************************************************************
// register map
// ********************************************************************
`define PMSM_CMD_OFFSET 8'h10
`define PMSM_LAUNCH_LANE 3
`define PMSM_CMD_RESET 30'h0000_0000
`define PMSM_RSVD_TOP 2'h0
`define PMSM_UNMAPPED_DATA 32'h0000_0000

// ********************************************************************
// field positions in the command word
// ********************************************************************
`define PMSM_IRQ_EN_BIT 29
`define PMSM_READY_BIT 28
`define PMSM_OP_MSB 27
`define PMSM_OP_LSB 26

// ********************************************************************
// serial frame layout, counted in bit periods from frame start
// ********************************************************************
`define PMSM_PREAMBLE 32'hffff_ffff
`define PMSM_START_CODE 2'h1
`define PMSM_TURNAROUND 2'h2
`define PMSM_RD_RELEASE_BIT 6'h2e
`define PMSM_RD_DATA_BIT 6'h30
`define PMSM_LAST_BIT 6'h3f

// ********************************************************************
// timing
// ********************************************************************
`define PMSM_CLK_PERIOD_NS 5
`define PMSM_MDC_MIN_PERIOD_NS 400

`endif

/* pmsm_pkg.sv */
/*
 * Types shared by the transceiver management serial master.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pmsm_pkg;

	// ****************************************************************
	// operation codes, command layout and engine states
	// ****************************************************************
	typedef logic [1:0] pmsm_op_t;

	localparam pmsm_op_t PMSM_OP_WRITE = 2'h1;
	localparam pmsm_op_t PMSM_OP_READ = 2'h2;

	typedef struct packed {
		logic done_irq_enable;
		logic ready;
		pmsm_op_t op;
		logic [4:0] xcvr_address;
		logic [4:0] xcvr_reg_index;
		logic [15:0] data;
	} pmsm_cmd_s;

	typedef enum logic [1:0] {
		PMSM_IDLE,
		PMSM_FRAME,
		PMSM_FINISH,
		PMSM_SETREADY
	} pmsm_state_e;

endpackage

/* pmsm_mdc_gen.sv */
/*
 * Management clock divider: toggles its output every HALF_CYCLES
 * system clocks while run is high and marks each edge with a pulse.
 * Assumes run is synchronous to i_clk.
 */
`timescale 1ns/10ps

module pmsm_mdc_gen #(
	parameter int HALF_CYCLES = 40
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_run,
	output logic o_mdc,
	output logic o_rise,
	output logic o_fall
);

	localparam int CW = $clog2(HALF_CYCLES + 1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_mdc;
	logic next_rise;
	logic next_fall;

	generate
		if (HALF_CYCLES < 1) begin : g_bad
			$error("HALF_CYCLES must be at least one");
		end
	endgenerate

	always_comb begin
		next_cnt = cnt;
		next_mdc = o_mdc;
		next_rise = 1'b0;
		next_fall = 1'b0;
		if (!i_run) begin
			// a stopped clock always parks low so a frame starts on a low half
			next_cnt = '0;
			next_mdc = 1'b0;
		end else if (cnt == CW'(HALF_CYCLES - 1)) begin
			next_cnt = '0;
			next_mdc = !o_mdc;
			next_rise = !o_mdc;
			next_fall = o_mdc;
		end else begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cnt <= '0;
			o_mdc <= 1'b0;
			o_rise <= 1'b0;
			o_fall <= 1'b0;
		end else if (i_clk_en) begin
			cnt <= next_cnt;
			o_mdc <= next_mdc;
			o_rise <= next_rise;
			o_fall <= next_fall;
		end
	end

endmodule // pmsm_mdc_gen

/* pmsm_master.sv */
/*
 * Transceiver management serial master: one command register, the
 * serial frame engine and read data capture.
 * Assumes a simple register port on I_CLK and a pin pad outside that
 * resolves the data line from O_MDIO_OUT and O_MDIO_OE.
 */
`timescale 1ns/10ps

`include "pmsm_params.svh"

module pmsm_master
	import pmsm_pkg::*;
#(
	parameter int CLK_PERIOD_NS = `PMSM_CLK_PERIOD_NS
) (
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic I_CLK_EN,
	input wire logic I_CSR_WR,
	input wire logic I_CSR_RD,
	input wire logic [7:0] I_CSR_ADDR,
	input wire logic [3:0] I_CSR_BE,
	input wire logic [31:0] I_CSR_WDATA,
	output logic [31:0] O_CSR_RDATA,
	output logic O_CSR_RVALID,
	output logic O_MDC,
	output logic O_MDIO_OUT,
	output logic O_MDIO_OE,
	input wire logic I_MDIO_IN,
	output logic O_DONE_IRQ
);

	// ****************************************************************
	// timing
	// ****************************************************************
	// least period, so round the half period up
	localparam int HALF_CYCLES = (`PMSM_MDC_MIN_PERIOD_NS
		+ 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

	generate
		if (CLK_PERIOD_NS < 1) begin : g_bad_clk
			$error("CLK_PERIOD_NS must be at least one");
		end
	endgenerate

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic hits_cmd(input logic [7:0] addr);
		hits_cmd = (addr[7:2] == 6'(`PMSM_CMD_OFFSET >> 2));
	endfunction

	function automatic logic [31:0] merge_lanes(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		merge_lanes = m;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	pmsm_state_e state;
	pmsm_state_e next_state;
	pmsm_cmd_s cmd;
	pmsm_cmd_s next_cmd;
	logic [31:0] stage;
	logic [31:0] next_stage;
	logic [63:0] shreg;
	logic [63:0] next_shreg;
	logic [5:0] bitcnt;
	logic [5:0] next_bitcnt;
	logic [15:0] rx;
	logic [15:0] next_rx;
	logic next_mdio_out;
	logic next_mdio_oe;
	logic next_irq;
	logic [31:0] next_rdata;
	logic next_rvalid;
	logic mdio_s1;
	logic mdio_s2;
	logic run;
	logic mdc_rise;
	logic mdc_fall;
	logic wr_hit;
	logic launch;
	logic [31:0] wr_word;

	pmsm_mdc_gen #(
		.HALF_CYCLES(HALF_CYCLES)
	) u_mdc (
		.i_clk(I_CLK),
		.i_reset_n(I_RESET_N),
		.i_clk_en(I_CLK_EN),
		.i_run(run),
		.o_mdc(O_MDC),
		.o_rise(mdc_rise),
		.o_fall(mdc_fall)
	);

	assign run = (state == PMSM_FRAME);

	// ****************************************************************
	// pin synchroniser
	// ****************************************************************
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			mdio_s1 <= 1'b0;
			mdio_s2 <= 1'b0;
		end else if (I_CLK_EN) begin
			mdio_s1 <= I_MDIO_IN;
			mdio_s2 <= mdio_s1;
		end
	end

	// ****************************************************************
	// register access and frame engine
	// ****************************************************************
	// writes are ignored while a frame runs; software must wait for ready
	assign wr_hit = I_CSR_WR && hits_cmd(I_CSR_ADDR) && (state == PMSM_IDLE);
	assign launch = wr_hit && I_CSR_BE[`PMSM_LAUNCH_LANE];
	assign wr_word = merge_lanes(stage, I_CSR_WDATA, I_CSR_BE);

	always_comb begin
		next_state = state;
		next_cmd = cmd;
		next_stage = stage;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_rx = rx;
		next_mdio_out = O_MDIO_OUT;
		next_mdio_oe = O_MDIO_OE;
		next_irq = 1'b0;
		next_rvalid = I_CSR_RD;
		next_rdata = `PMSM_UNMAPPED_DATA;
		if (I_CSR_RD && hits_cmd(I_CSR_ADDR)) begin
			next_rdata = {`PMSM_RSVD_TOP, cmd};
		end
		if (wr_hit) begin
			// lower lanes only stage; nothing reaches the command yet
			next_stage = wr_word;
		end
		unique case (state)
			PMSM_IDLE: begin
				next_mdio_oe = 1'b0;
				if (launch) begin
					next_cmd = pmsm_cmd_s'(wr_word[29:0]);
					next_bitcnt = '0;
					next_rx = '0;
					next_shreg = {`PMSM_PREAMBLE, `PMSM_START_CODE,
						wr_word[`PMSM_OP_MSB:`PMSM_OP_LSB],
						wr_word[25:21], wr_word[20:16],
						`PMSM_TURNAROUND, wr_word[15:0]};
					if (wr_word[`PMSM_OP_MSB:`PMSM_OP_LSB] == PMSM_OP_WRITE ||
						wr_word[`PMSM_OP_MSB:`PMSM_OP_LSB] == PMSM_OP_READ) begin
						next_state = PMSM_FRAME;
						next_mdio_out = 1'(`PMSM_PREAMBLE >> 31);
						next_mdio_oe = 1'b1;
					end else begin
						// reserved codes send nothing but still complete
						next_state = PMSM_FINISH;
					end
				end
			end
			PMSM_FRAME: begin
				if (mdc_rise && cmd.op == PMSM_OP_READ &&
					bitcnt >= `PMSM_RD_DATA_BIT) begin
					next_rx = {rx[14:0], mdio_s2};
				end
				if (mdc_fall) begin
					if (bitcnt == `PMSM_LAST_BIT) begin
						next_state = PMSM_FINISH;
						next_mdio_oe = 1'b0;
					end else begin
						next_bitcnt = bitcnt + 6'h01;
						next_shreg = {shreg[62:0], 1'b0};
						next_mdio_out = shreg[62];
						next_mdio_oe = (cmd.op == PMSM_OP_WRITE) ||
							(next_bitcnt < `PMSM_RD_RELEASE_BIT);
					end
				end
			end
			PMSM_FINISH: begin
				next_irq = cmd.done_irq_enable;
				if (cmd.op == PMSM_OP_READ) begin
					next_cmd.data = rx;
				end
				next_state = PMSM_SETREADY;
			end
			PMSM_SETREADY: begin
				next_cmd.ready = 1'b1;
				next_state = PMSM_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			state <= PMSM_IDLE;
			cmd <= `PMSM_CMD_RESET;
			stage <= 32'h0000_0000;
			shreg <= 64'h0000_0000_0000_0000;
			bitcnt <= 6'h00;
			rx <= 16'h0000;
			O_MDIO_OUT <= 1'b0;
			O_MDIO_OE <= 1'b0;
			O_DONE_IRQ <= 1'b0;
			O_CSR_RDATA <= 32'h0000_0000;
			O_CSR_RVALID <= 1'b0;
		end else if (I_CLK_EN) begin
			state <= next_state;
			cmd <= next_cmd;
			stage <= next_stage;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			rx <= next_rx;
			O_MDIO_OUT <= next_mdio_out;
			O_MDIO_OE <= next_mdio_oe;
			O_DONE_IRQ <= next_irq;
			O_CSR_RDATA <= next_rdata;
			O_CSR_RVALID <= next_rvalid;
		end
	end

endmodule // pmsm_master

/* pmsm_checker.sv */
/* port checker for the management serial master.
   assumes a bind onto pmsm_master and a single clock domain. */
`timescale 1ns/10ps
module pmsm_checker #(
	parameter int CLK_PERIOD_NS = 5
) (
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic I_CSR_RD,
	input wire logic [7:0] I_CSR_ADDR,
	input wire logic [31:0] O_CSR_RDATA,
	input wire logic O_CSR_RVALID,
	input wire logic O_MDC,
	input wire logic O_MDIO_OUT,
	input wire logic O_MDIO_OE,
	input wire logic O_DONE_IRQ
);
	// ****
	// helper: cycles since the management clock last moved
	// ****
	localparam int HALF = (400 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	logic [7:0] since;
	logic [7:0] next_since;
	logic mdc_q;
	always_comb begin
		next_since = (since == 8'hff) ? since : since + 8'h01;
		if (!I_RESET_N || O_MDC != mdc_q) begin
			next_since = 8'h00;
		end
	end
	always_ff @(posedge I_CLK) begin
		since <= next_since;
		mdc_q <= O_MDC;
	end
	// ****
	// assertions
	// ****
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);
	rd_answer_a: assert property (I_CSR_RD |=> O_CSR_RVALID)
		else $error("read strobe got no answer");
	top_zero_a: assert property (O_CSR_RVALID |-> O_CSR_RDATA[31:30] == 2'h0)
		else $error("reserved top bits read nonzero");
	unmapped_zero_a: assert property
		(I_CSR_RD && I_CSR_ADDR[7:2] != 6'h04 |=> O_CSR_RDATA == 32'h0)
		else $error("unmapped read not zero");
	mdc_half_a: assert property ($changed(O_MDC) |-> since >= HALF - 1)
		else $error("management clock half period too short");
	irq_pulse_a: assert property (O_DONE_IRQ |=> !O_DONE_IRQ)
		else $error("done interrupt wider than one cycle");
	data_at_low_a: assert property
		(O_MDIO_OE && $past(O_MDIO_OE) && $changed(O_MDIO_OUT) |-> !O_MDC)
		else $error("data moved while clock high");
	frame_open_a: assert property ($rose(O_MDIO_OE) |-> !O_MDC && O_MDIO_OUT)
		else $error("frame opened without preamble one");
	release_low_a: assert property ($fell(O_MDIO_OE) |-> !O_MDC)
		else $error("pin released while clock high");
	irq_quiet_a: assert property (O_DONE_IRQ |-> !O_MDIO_OE && !O_MDC)
		else $error("interrupt before the frame ended");
	cover property (O_DONE_IRQ);
	cover property ($fell(O_MDIO_OE));
	cover property (I_CSR_RD && I_CSR_ADDR[7:2] != 6'h04);
endmodule // pmsm_checker

bind pmsm_master pmsm_checker #(.CLK_PERIOD_NS(CLK_PERIOD_NS)) chk (
	.I_CLK(I_CLK),
	.I_RESET_N(I_RESET_N),
	.I_CSR_RD(I_CSR_RD),
	.I_CSR_ADDR(I_CSR_ADDR),
	.O_CSR_RDATA(O_CSR_RDATA),
	.O_CSR_RVALID(O_CSR_RVALID),
	.O_MDC(O_MDC),
	.O_MDIO_OUT(O_MDIO_OUT),
	.O_MDIO_OE(O_MDIO_OE),
	.O_DONE_IRQ(O_DONE_IRQ)
);

/* pmsm_phy_model.sv */
/* behavioural transceiver on the management pin.
   assumes the master opens each frame by raising its output enable. */
`timescale 1ns/10ps
module pmsm_phy_model #(
	parameter logic [15:0] RD_DATA = 16'hc3a5
) (
	input wire logic i_mdc,
	input wire logic i_oe,
	input wire logic i_out,
	output logic o_pin,
	output logic [63:0] o_frame,
	output logic [6:0] o_bits,
	output logic [6:0] o_driven
);
	// ****
	// pin resolution and frame capture
	// ****
	logic phy_oe = 1'b0;
	logic phy_bit = 1'b0;
	logic rd = 1'b0;
	// pull-up: an undriven line reads one
	assign o_pin = i_oe ? i_out : (phy_oe ? phy_bit : 1'b1);
	initial begin
		o_frame = 64'h0;
		o_bits = 7'h0;
		o_driven = 7'h0;
	end
	always @(posedge i_oe) begin
		o_bits = 7'h0;
		o_driven = 7'h0;
	end
	always @(posedge i_mdc) begin
		o_frame = {o_frame[62:0], o_pin};
		o_bits = o_bits + 7'h1;
		o_driven = o_driven + {6'h0, i_oe};
		if (o_bits == 7'h24) begin
			rd = (o_frame[1:0] == 2'h2);
		end
	end
	// answer moves just after the falling edge, steady at the rise
	always @(negedge i_mdc) begin
		phy_oe = rd && o_bits >= 7'h2f && o_bits <= 7'h3f;
		phy_bit = (o_bits == 7'h2f) ? 1'b0 : RD_DATA[63 - int'(o_bits)];
	end
endmodule // pmsm_phy_model

/* tb_phy_mgmt_serial_master.sv */
/* self-checking bench for the management serial master.
   assumes pmsm_pkg, the checker and the transceiver model. */
`timescale 1ns/10ps
module tb_phy_mgmt_serial_master;
	import pmsm_pkg::*;
	logic clk = 1'b0;
	logic en = 1'b1;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h0;
	logic [3:0] be = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic rvalid, mdc, mdo, oe, pin, irq;
	logic [63:0] frame;
	logic [6:0] bits, driven;
	int fail_count = 0;
	int checks_done = 0;
	int irqs = 0;
	int rises = 0;
	always #2.5 clk = ~clk;
	always @(negedge clk) if (irq === 1'b1) irqs++;
	always @(posedge mdc) rises++;
	pmsm_master #(.CLK_PERIOD_NS(5)) uut (.I_CLK(clk), .I_RESET_N(rst_n),
		.I_CLK_EN(en), .I_CSR_WR(wr), .I_CSR_RD(rd), .I_CSR_ADDR(addr),
		.I_CSR_BE(be), .I_CSR_WDATA(wdata), .O_CSR_RDATA(rdata),
		.O_CSR_RVALID(rvalid), .O_MDC(mdc), .O_MDIO_OUT(mdo),
		.O_MDIO_OE(oe), .I_MDIO_IN(pin), .O_DONE_IRQ(irq));
	pmsm_phy_model phy (.i_mdc(mdc), .i_oe(oe), .i_out(mdo), .o_pin(pin),
		.o_frame(frame), .o_bits(bits), .o_driven(driven));
	// ****
	// shared tasks
	// ****
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task csr_wr(input logic [3:0] b, input logic [31:0] d);
		@(negedge clk) {wr, be, wdata, addr} = {1'b1, b, d, 8'h10};
		@(negedge clk) wr = 1'b0;
	endtask
	task csr_rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk) {rd, addr} = {1'b1, a};
		@(negedge clk) rd = 1'b0;
		for (int i = 0; i < 3 && rvalid !== 1'b1; i++) @(negedge clk);
		if (rvalid !== 1'b1) begin
			fail_count++;
			$display("mismatch t=%0t read got no answer", $time);
			summarize();
		end
		d = rdata;
	endtask
	// polls until ready; a stuck engine ends the run
	task wait_ready(output logic [31:0] d);
		for (int i = 0; i < 4000; i++) begin
			csr_rd(8'h10, d);
			if (d[28] === 1'b1) return;
		end
		fail_count++;
		$display("mismatch t=%0t ready never set", $time);
		summarize();
	endtask
	// ****
	// scenarios
	// ****
	task t_reset;
		logic [31:0] d;
		csr_rd(8'h10, d);
		check(64'(d), 64'h0);
		csr_rd(8'h14, d);
		check(64'(d), 64'h0);
		$display("test reset done");
	endtask
	task t_write;
		logic [31:0] d;
		logic [31:0] w;
		int r;
		w = {2'h3, 1'b1, 1'b0, PMSM_OP_WRITE, 5'h15, 5'h1f, 16'h8001};
		csr_wr(4'hf, w);
		csr_wr(4'hf, 32'h0);
		// a low enable must stall the frame without corrupting it
		@(negedge clk) en = 1'b0;
		r = rises;
		repeat (60) @(negedge clk);
		check(64'(rises), 64'(r));
		en = 1'b1;
		wait_ready(d);
		check(64'(irqs), 64'h1);
		check(64'(d), 64'(w & 32'h3fff_ffff | 32'h1000_0000));
		check(frame, {32'hffff_ffff, 4'h5, 10'h2bf, 2'h2, 16'h8001});
		check(64'(driven), 64'h40);
		$display("test write done");
	endtask
	task t_read;
		logic [31:0] d;
		logic [31:0] w;
		w = {2'h0, 1'b0, 1'b0, PMSM_OP_READ, 5'h1b, 5'h0a, 16'h1234};
		csr_wr(4'h1, w);
		csr_wr(4'h2, w);
		csr_wr(4'h4, w);
		check(64'(oe), 64'h0);
		csr_wr(4'h8, w);
		wait_ready(d);
		check(64'(d), 64'({2'h0, 1'b0, 1'b1, PMSM_OP_READ, 5'h1b, 5'h0a,
			16'hc3a5}));
		check(64'(irqs), 64'h1);
		check(frame, {32'hffff_ffff, 4'h6, 10'h36a, 2'h2, 16'hc3a5});
		check(64'(driven), 64'h2e);
		$display("test read done");
	endtask
	task t_reserved;
		logic [31:0] d;
		int r;
		for (int op = 0; op < 4; op += 3) begin
			r = rises;
			csr_wr(4'hf, {2'h0, 1'b1, 1'b0, 2'(op), 26'h0});
			wait_ready(d);
			check(64'(rises), 64'(r));
			check(64'(irqs), 64'(2 + op / 3));
		end
		$display("test reserved done");
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_write();
		t_read();
		t_reserved();
		summarize();
	end
endmodule // tb_phy_mgmt_serial_master
